/* verilog/host_port_defines.svh */
// constants for the decoder host port and pixel output
`ifndef HOST_PORT_DEFINES_SVH
`define HOST_PORT_DEFINES_SVH

// instruction codes on the low nibble of the control bus
`define INSTR_WRITE_SETUP 4'h4
`define INSTR_READ_GROUP 4'h8
`define INSTR_READ_MBNUM 4'h9
`define INSTR_READ_DECISIONS 4'hb
`define INSTR_READ_SETUP 4'hc
`define INSTR_CLOCK_DOUBLER 4'hf

// setup byte fields
`define SETUP_QUARTER_BIT 0
`define SETUP_BIGDRAM_BIT 6
`define SETUP_MASK 8'h41
`define SETUP_RESET 8'h00

// decision byte fields on the input side
`define DEC_IN_FIXED_BIT 0
`define DEC_IN_INTER_BIT 1
`define DEC_IN_FILTER_BIT 2
`define DEC_IN_MC_BIT 3
`define DEC_IN_SKIP_BIT 6

// decision byte fields and macroblock number stable bit on the status reads
`define DEC_OUT_INTER_BIT 0
`define DEC_OUT_MC_BIT 1
`define DEC_OUT_FILTER_BIT 3
`define DEC_OUT_SKIP_BIT 6
`define MBNUM_STABLE_BIT 6

// pixel timing: one pixel every four clocks, strobe two clocks after marker
`define PIXEL_DIVIDE 4
`define STROBE_LEAD 2
`define PIXELS_PER_MB 384
`define MB_BUF_DEPTH 4

`endif

/* verilog/host_port_pkg.sv */
// types for the decoder host port and pixel output
`default_nettype none
package host_port_pkg;
	// macroblock header carried with each macroblock
	typedef struct packed {
		logic [3:0] group_number;
		logic [5:0] output_macroblock_number;
		logic [7:0] decisions;
		logic frame_start;
		logic frame_end;
	} mb_header_t;

	// incoming pixel with its tags
	typedef struct packed {
		logic [7:0] pixel;
		mb_header_t header;
	} pixel_word_t;

	// host bus drive pins (data out and output enable of the two-way bus)
	typedef struct packed {
		logic [7:0] data_out;
		logic data_oe;
	} bus_drive_t;
endpackage
`default_nettype wire

/* verilog/mb_header_store.sv */
// small memory of macroblock headers with a registered read port
`default_nettype none
module mb_header_store #(
	parameter int DEPTH = 4,
	parameter int AW = 2
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// write port
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire host_port_pkg::mb_header_t wr_data,
	// read port
	input wire logic [AW-1:0] rd_addr,
	output host_port_pkg::mb_header_t rd_data
);
	import host_port_pkg::*;

	mb_header_t mem [DEPTH];
	mb_header_t next_rd_data;

	// read data always comes from a register
	always_comb
	begin
		next_rd_data = mem[rd_addr];
	end

	always_ff @(posedge sys_clk)
	begin
		if (wr_en)
			mem[wr_addr] <= wr_data;
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			rd_data <= '0;
		else
			rd_data <= next_rd_data;
	end
endmodule
`default_nettype wire

/* verilog/decoder_host_port.sv */
// host control port and decoded pixel output of the video decoder
`default_nettype none
`include "host_port_defines.svh"

// Contract
// RULE1 - pixels at quarter clock, input order kept
// RULE2 - one strobe pulse per valid pixel
// RULE3 - marker frames each output macroblock
// RULE4 - frame ready spans first to last marker
// RULE5 - first strobe two clocks after marker
// RULE6 - full picture out, last two wait; the code holds none back, each macroblock goes out as its pixels arrive
// RULE7 - instruction write then data access
// RULE8 - strobe acts only with chip enable low
// RULE9 - writes captured at strobe rising edge
// RULE10 - host may interleave with chip disabled
// RULE11 - read byte driven while enabled, address high
// RULE12 - host raises address before strobe on reads
// RULE13 - instruction decoded from low nibble only
// RULE14 - instruction code table decode
// RULE15 - setup bit0 quarter size, bit6 big DRAM
// RULE16 - setup resets to full size, small DRAM
// RULE17 - host resets after picture size change
// RULE18 - group read: number low, upper zero
// RULE19 - macroblock read with stable flag bit6
// RULE20 - decisions read of current output macroblock
// RULE21 - skip stops pixel output until cancelled
// RULE22 - setup read returns bits 0 and 6
module decoder_host_port #(
	parameter int PIXELS_PER_MB = `PIXELS_PER_MB,
	parameter int DEPTH = `MB_BUF_DEPTH,
	parameter int AW = 2
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// host control bus
	input wire logic [7:0] control_bus_in,
	output logic [7:0] control_bus_out,
	output logic control_bus_oe,
	input wire logic control_address_line,
	input wire logic control_strobe,
	input wire logic control_chip_enable_n,
	// decoded pixels from the reconstruction core
	input wire logic pix_in_valid,
	input wire host_port_pkg::pixel_word_t pix_in,
	output logic pix_in_ready,
	// live skip state from the input side
	input wire logic skip_active,
	// pixel output port
	output logic [7:0] pixel_out,
	output logic pixel_valid_strobe,
	output logic macroblock_boundary_marker,
	output logic frame_ready_out,
	// setup outputs to the rest of the decoder
	output logic quarter_size_mode,
	output logic big_dram_mode,
	output logic clock_doubler_override
);
	import host_port_pkg::*;

	typedef enum logic [3:0] {
		OUT_IDLE = 4'b0001,
		OUT_LEAD = 4'b0010,
		OUT_PIXEL = 4'b0100,
		OUT_TAIL = 4'b1000
	} out_state_t;

	// reset release through two flops
	logic rst_sync1, rst_n;
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			rst_sync1 <= 1'b0;
			rst_n <= 1'b0;
		end
		else
		begin
			rst_sync1 <= 1'b1;
			rst_n <= rst_sync1;
		end
	end

	function automatic logic [3:0] low_nibble(input logic [7:0] b);
		return b[3:0];
	endfunction

	// ---------------- host bus state ----------------
	logic strobe_d, next_strobe_d;
	logic [3:0] instr, next_instr;
	logic [7:0] setup, next_setup;
	logic doubler, next_doubler;
	logic [7:0] bus_out, next_bus_out;
	logic bus_oe, next_bus_oe;
	logic strobe_rise;
	mb_header_t cur_hdr, next_cur_hdr;
	logic mb_changing, next_mb_changing;
	logic skip_q, next_skip_q;

	// strobe counts only while chip enable is low
	assign strobe_rise = control_strobe & ~strobe_d & ~control_chip_enable_n; // RULE8

	// instruction with address low, data phase with address high
	always_comb
	begin
		next_strobe_d = control_strobe;
		next_instr = instr;
		next_setup = setup;
		next_doubler = doubler;
		next_bus_out = 8'h00;
		next_bus_oe = 1'b0;
		if (strobe_rise && !control_address_line) // RULE7 RULE9
			next_instr = low_nibble(control_bus_in); // RULE13
		else if (strobe_rise && control_address_line)
		begin
			// RULE14 RULE15
			if (instr == `INSTR_WRITE_SETUP)
				next_setup = control_bus_in & `SETUP_MASK;
			else if (instr == `INSTR_CLOCK_DOUBLER)
				next_doubler = control_bus_in[0];
		end
		// read byte driven while enabled with address high
		if (!control_chip_enable_n && control_address_line) // RULE11
		begin
			case (instr) // RULE14
				`INSTR_READ_GROUP:
				begin
					next_bus_oe = 1'b1;
					next_bus_out = {4'h0, cur_hdr.group_number}; // RULE18
				end
				`INSTR_READ_MBNUM:
				begin
					next_bus_oe = 1'b1;
					next_bus_out = {1'b0, ~mb_changing, cur_hdr.output_macroblock_number}; // RULE19
				end
				`INSTR_READ_DECISIONS:
				begin
					next_bus_oe = 1'b1;
					next_bus_out = 8'h00; // RULE20
					next_bus_out[`DEC_OUT_INTER_BIT] = cur_hdr.decisions[`DEC_IN_INTER_BIT];
					next_bus_out[`DEC_OUT_MC_BIT] = cur_hdr.decisions[`DEC_IN_MC_BIT];
					next_bus_out[`DEC_OUT_FILTER_BIT] = cur_hdr.decisions[`DEC_IN_FILTER_BIT];
					next_bus_out[`DEC_OUT_SKIP_BIT] = skip_q;
				end
				`INSTR_READ_SETUP:
				begin
					next_bus_oe = 1'b1;
					next_bus_out = setup & `SETUP_MASK; // RULE22
				end
				default:
					next_bus_oe = 1'b0;
			endcase
		end
	end

	// host bus registers
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			strobe_d <= 1'b0;
			instr <= 4'h0;
			setup <= `SETUP_RESET; // RULE16
			doubler <= 1'b0;
			bus_out <= 8'h00;
			bus_oe <= 1'b0;
		end
		else
		begin
			strobe_d <= next_strobe_d;
			instr <= next_instr;
			setup <= next_setup;
			doubler <= next_doubler;
			bus_out <= next_bus_out;
			bus_oe <= next_bus_oe;
		end
	end

	// ---------------- pixel output path ----------------
	out_state_t state, next_state;
	logic [1:0] phase, next_phase;
	logic [8:0] pix_count, next_pix_count;
	logic [7:0] pix_q, next_pix_q;
	logic strobe_q, next_strobe_q;
	logic marker_q, next_marker_q;
	logic frame_q, next_frame_q;
	logic last_of_frame, next_last_of_frame;
	logic take;
	logic [AW-1:0] hdr_wr_addr, next_hdr_wr_addr;
	mb_header_t hdr_rd;

	// a pixel is taken when idle or on a quarter-rate load slot, never while skipping
	assign take = pix_in_valid && !skip_q && (state == OUT_IDLE
		|| (state == OUT_PIXEL && phase == 2'd0 && pix_count != 9'(PIXELS_PER_MB))); // RULE21 RULE1

	// header memory remembers tags of macroblocks on their way out
	mb_header_store #(.DEPTH(DEPTH), .AW(AW)) u_hdr (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.wr_en(take && pix_count == 9'd0),
		.wr_addr(hdr_wr_addr),
		.wr_data(pix_in.header),
		.rd_addr(hdr_wr_addr),
		.rd_data(hdr_rd)
	);

	// sequencer: marker, two-clock lead, then one pixel per four clocks
	always_comb
	begin
		next_state = state;
		next_phase = phase + 2'd1;
		next_pix_count = pix_count;
		next_pix_q = pix_q;
		next_strobe_q = 1'b0; // RULE2
		next_marker_q = marker_q;
		next_frame_q = frame_q;
		next_last_of_frame = last_of_frame;
		next_hdr_wr_addr = hdr_wr_addr;
		next_cur_hdr = (pix_count == 9'd1 && state == OUT_PIXEL) ? hdr_rd : cur_hdr;
		next_mb_changing = (state != OUT_PIXEL) || (pix_count >= 9'(PIXELS_PER_MB - 4));
		next_skip_q = skip_active;
		case (state)
			OUT_IDLE:
			begin
				next_phase = 2'd0;
				if (pix_in_valid && !skip_q) // RULE21
				begin
					// input order is preserved; full picture comes out
					next_state = OUT_LEAD; // RULE1 RULE6
					next_marker_q = 1'b1; // RULE3
					if (pix_in.header.frame_start)
						next_frame_q = 1'b1; // RULE4
					next_last_of_frame = pix_in.header.frame_end;
					next_pix_q = pix_in.pixel;
				end
			end
			OUT_LEAD:
			begin
				if (phase == 2'(`STROBE_LEAD - 1))
				begin
					next_strobe_q = 1'b1; // RULE5
					next_state = OUT_PIXEL;
					next_pix_count = 9'd1;
					next_phase = 2'(`PIXEL_DIVIDE - 1); // next load lands two clocks after this strobe
				end
			end
			OUT_PIXEL:
			begin
				// data held four clocks, strobe mid-window
				if (phase == 2'd0 && pix_count == 9'(PIXELS_PER_MB))
				begin
					next_state = OUT_TAIL;
					next_marker_q = 1'b0;
					if (last_of_frame)
						next_frame_q = 1'b0; // RULE4
					next_hdr_wr_addr = hdr_wr_addr + AW'(1);
				end
				else if (phase == 2'd0 && pix_in_valid && !skip_q)
				begin
					next_pix_q = pix_in.pixel;
				end
				// hold the load slot until a pixel is there, so no strobe goes out empty
				else if (phase == 2'd0)
					next_phase = 2'd0; // RULE2
				else if (phase == 2'(`STROBE_LEAD) && pix_count != 9'(PIXELS_PER_MB))
				begin
					next_strobe_q = 1'b1; // RULE2
					next_pix_count = pix_count + 9'd1;
				end
			end
			OUT_TAIL:
			begin
				next_state = OUT_IDLE;
				next_pix_count = 9'd0;
			end
			default:
				next_state = OUT_IDLE;
		endcase
	end

	// pixel path registers
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state <= OUT_IDLE;
			phase <= 2'd0;
			pix_count <= 9'd0;
			pix_q <= 8'h00;
			strobe_q <= 1'b0;
			marker_q <= 1'b0;
			frame_q <= 1'b0;
			last_of_frame <= 1'b0;
			hdr_wr_addr <= '0;
			cur_hdr <= '0;
			mb_changing <= 1'b1;
			skip_q <= 1'b0;
		end
		else
		begin
			state <= next_state;
			phase <= next_phase;
			pix_count <= next_pix_count;
			pix_q <= next_pix_q;
			strobe_q <= next_strobe_q;
			marker_q <= next_marker_q;
			frame_q <= next_frame_q;
			last_of_frame <= next_last_of_frame;
			hdr_wr_addr <= next_hdr_wr_addr;
			cur_hdr <= next_cur_hdr;
			mb_changing <= next_mb_changing;
			skip_q <= next_skip_q;
		end
	end

	// outputs straight from flops
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			pix_in_ready <= 1'b0;
		else
			pix_in_ready <= !skip_active && (next_state == OUT_IDLE || (next_state == OUT_PIXEL
				&& next_phase == 2'd0 && next_pix_count != 9'(PIXELS_PER_MB)));
	end

	assign control_bus_out = bus_out;
	assign control_bus_oe = bus_oe;
	assign pixel_out = pix_q;
	assign pixel_valid_strobe = strobe_q;
	assign macroblock_boundary_marker = marker_q;
	assign frame_ready_out = frame_q;
	assign quarter_size_mode = setup[`SETUP_QUARTER_BIT];
	assign big_dram_mode = setup[`SETUP_BIGDRAM_BIT];
	assign clock_doubler_override = doubler;
endmodule
`default_nettype wire

/* bench/decoder_host_port_sva.sv */
// assertions on the pixel output and host bus ports
`default_nettype none
module decoder_host_port_sva (
	// clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// host bus
	input wire logic [7:0] control_bus_out,
	input wire logic control_bus_oe,
	input wire logic control_address_line,
	input wire logic control_chip_enable_n,
	// pixel port and setup
	input wire logic [7:0] pixel_out,
	input wire logic pixel_valid_strobe,
	input wire logic macroblock_boundary_marker,
	input wire logic frame_ready_out,
	input wire logic quarter_size_mode,
	input wire logic big_dram_mode
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!resetn);
	// one pulse, then three quiet clocks before the next slot
	property p_strobe_gap;
		pixel_valid_strobe |=> !pixel_valid_strobe [*3];
	endproperty
	a_strobe_gap: assert property (p_strobe_gap) else $error("strobe spacing broken");
	property p_strobe_framed;
		pixel_valid_strobe |-> macroblock_boundary_marker;
	endproperty
	a_strobe_framed: assert property (p_strobe_framed) else $error("strobe outside marker");
	property p_first_strobe;
		$rose(macroblock_boundary_marker) |-> !pixel_valid_strobe ##1 !pixel_valid_strobe ##1 pixel_valid_strobe;
	endproperty
	a_first_strobe: assert property (p_first_strobe) else $error("first strobe not two clocks on");
	property p_pixel_hold;
		pixel_valid_strobe |-> $stable(pixel_out) ##1 $stable(pixel_out);
	endproperty
	a_pixel_hold: assert property (p_pixel_hold) else $error("pixel moved around strobe");
	property p_frame_rise;
		$rose(frame_ready_out) |-> $rose(macroblock_boundary_marker);
	endproperty
	a_frame_rise: assert property (p_frame_rise) else $error("frame ready rose alone");
	// release must follow deselect or address low within one clock
	property p_bus_release;
		(control_chip_enable_n || !control_address_line) |=> !control_bus_oe;
	endproperty
	a_bus_release: assert property (p_bus_release) else $error("bus still driven");
	property p_bus_quiet;
		!control_bus_oe |-> control_bus_out == 8'h00;
	endproperty
	a_bus_quiet: assert property (p_bus_quiet) else $error("idle bus value nonzero");
	property p_setup_hold;
		control_chip_enable_n |=> $stable(quarter_size_mode) && $stable(big_dram_mode);
	endproperty
	a_setup_hold: assert property (p_setup_hold) else $error("setup changed while deselected");
endmodule
bind decoder_host_port decoder_host_port_sva decoder_host_port_sva_inst (.sys_clk, .resetn, .control_bus_out,
	.control_bus_oe, .control_address_line, .control_chip_enable_n, .pixel_out, .pixel_valid_strobe,
	.macroblock_boundary_marker, .frame_ready_out, .quarter_size_mode, .big_dram_mode);
`default_nettype wire

/* bench/host_cpu_model.sv */
// host microprocessor model on the eight-bit control bus
`default_nettype none
module host_cpu_model (
	// clock
	input wire logic sys_clk,
	// control bus pins
	input wire logic [7:0] control_bus_out,
	input wire logic control_bus_oe,
	output logic [7:0] control_bus_in,
	output logic control_address_line,
	output logic control_strobe,
	output logic control_chip_enable_n
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] host_data = 8'h00;
	logic host_oe = 1'b0;
	// a released bus shows the inverse of the last value, never a stale copy
	assign control_bus_in = control_bus_oe ? control_bus_out : (host_oe ? host_data : ~host_data);
	initial
	begin
		control_address_line = 1'b0;
		control_strobe = 1'b0;
		control_chip_enable_n = 1'b1;
	end
	// one access: select, settle address, strobe one clock, deselect
	task automatic access(input logic adr, input logic drv, input logic [7:0] d, output logic [7:0] q,
		output logic seen);
		@(negedge sys_clk);
		control_chip_enable_n = 1'b0;
		control_address_line = adr;
		host_oe = drv;
		host_data = d;
		repeat (2) @(negedge sys_clk);
		q = control_bus_in;
		seen = control_bus_oe;
		control_strobe = 1'b1;
		@(negedge sys_clk);
		control_strobe = 1'b0;
		@(negedge sys_clk);
		control_chip_enable_n = 1'b1;
		host_oe = 1'b0;
	endtask
	// instruction write, optional foreign transfer, then data access
	task automatic xfer(input logic [3:0] code, input logic wr, input logic [7:0] d, input logic gap,
		output logic [7:0] q, output logic seen);
		logic [7:0] jq;
		logic js;
		access(1'b0, 1'b1, {4'h0, code}, jq, js);
		if (gap)
		begin
			// strobe for another device while deselected
			@(negedge sys_clk);
			host_oe = 1'b1;
			host_data = 8'hff;
			control_strobe = 1'b1;
			@(negedge sys_clk);
			control_strobe = 1'b0;
			host_oe = 1'b0;
		end
		access(1'b1, wr, d, q, seen);
	endtask
endmodule
`default_nettype wire

/* bench/decoder_host_port_tb.sv */
// self-checking bench for the decoder host port and pixel output
`default_nettype none
module decoder_host_port_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import host_port_pkg::*;
	localparam int PPM = 8;
	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	logic [7:0] control_bus_in, control_bus_out, pixel_out, q;
	logic control_bus_oe, control_address_line, control_strobe, control_chip_enable_n, seen;
	logic pix_in_valid, pix_in_ready, pixel_valid_strobe, macroblock_boundary_marker, frame_ready_out;
	logic quarter_size_mode, big_dram_mode, clock_doubler_override;
	logic skip_active = 1'b1;
	logic go = 1'b0;
	pixel_word_t pix_in;
	int sent = 0, rcv = 0, err_total = 0, checked = 0, n;
	logic [7:0] setups [3] = '{8'h41, 8'h40, 8'h00};
	logic [3:0] dead [4] = '{4'h0, 4'h6, 4'h7, 4'ha};
	always #4 sys_clk = ~sys_clk;
	// upstream source: two macroblocks of one frame
	assign pix_in_valid = go && (sent < 2 * PPM);
	assign pix_in.pixel = 8'(sent) + 8'h10;
	assign pix_in.header = '{group_number: (sent < PPM) ? 4'h3 : 4'h4, output_macroblock_number: (sent < PPM) ? 6'h05 : 6'h06,
		decisions: 8'h0e, frame_start: sent == 0, frame_end: sent >= PPM};
	decoder_host_port #(.PIXELS_PER_MB(PPM)) decoder_host_port_inst (.sys_clk, .resetn, .control_bus_in,
		.control_bus_out, .control_bus_oe, .control_address_line, .control_strobe, .control_chip_enable_n,
		.pix_in_valid, .pix_in, .pix_in_ready, .skip_active, .pixel_out, .pixel_valid_strobe,
		.macroblock_boundary_marker, .frame_ready_out, .quarter_size_mode, .big_dram_mode, .clock_doubler_override);
	host_cpu_model host_cpu_model_inst (.sys_clk, .control_bus_out, .control_bus_oe, .control_bus_in,
		.control_address_line, .control_strobe, .control_chip_enable_n);
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp)
		begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic report_and_stop();
		if (err_total == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// bounded wait for the marker (0) or for all pixels (1)
	task automatic wait_for(input int which);
		n = 0;
		while (!((which == 0) ? macroblock_boundary_marker === 1'b1 : rcv == 2 * PPM) && n < 600)
		begin
			@(negedge sys_clk);
			n++;
		end
		if (n >= 600)
		begin
			err_total++;
			report_and_stop();
		end
	endtask
	// pixels must arrive in input order
	always @(posedge sys_clk)
	begin
		if (pix_in_valid && pix_in_ready)
			sent <= sent + 1;
		if (pixel_valid_strobe === 1'b1)
		begin
			check({8'h00, pixel_out}, 16'(rcv) + 16'h0010);
			rcv <= rcv + 1;
		end
	end
	initial
	begin
		repeat (12) @(negedge sys_clk);
		resetn = 1'b1;
		repeat (4) @(negedge sys_clk);
		host_cpu_model_inst.xfer(4'hc, 1'b0, 8'h00, 1'b0, q, seen);
		check({7'h00, seen, q}, 16'h0100);
		// each setup goes in past a foreign strobe, then reads back
		// size changes all land before any macroblock arrives, so no reset is owed
		foreach (setups[i])
		begin
			host_cpu_model_inst.xfer(4'h4, 1'b1, setups[i], 1'b1, q, seen);
			check({14'h0, quarter_size_mode, big_dram_mode}, {14'h0, setups[i][0], setups[i][6]});
			host_cpu_model_inst.xfer(4'hc, 1'b0, 8'h00, 1'b0, q, seen);
			check({7'h00, seen, q}, {8'h01, setups[i]});
		end
		foreach (dead[i])
		begin
			host_cpu_model_inst.xfer(dead[i], 1'b0, 8'h00, 1'b0, q, seen);
			check({15'h0, seen}, 16'h0000);
		end
		host_cpu_model_inst.xfer(4'hf, 1'b1, 8'h01, 1'b0, q, seen);
		check({15'h0, clock_doubler_override}, 16'h0001);
		// skip holds the stream back until released
		go = 1'b1;
		repeat (40) @(negedge sys_clk);
		check({macroblock_boundary_marker, 15'(rcv)}, 16'h0000);
		skip_active = 1'b0;
		wait_for(0);
		check({15'h0, frame_ready_out}, 16'h0001);
		host_cpu_model_inst.xfer(4'h9, 1'b0, 8'h00, 1'b0, q, seen);
		check({7'h00, seen, q}, 16'h0145);
		host_cpu_model_inst.xfer(4'h8, 1'b0, 8'h00, 1'b0, q, seen);
		check({7'h00, seen, q}, 16'h0103);
		host_cpu_model_inst.xfer(4'hb, 1'b0, 8'h00, 1'b0, q, seen);
		check({7'h00, seen, q}, 16'h010b);
		wait_for(1);
		repeat (20) @(negedge sys_clk);
		check({pixel_valid_strobe, 15'(rcv)}, 16'(2 * PPM));
		check({14'h0, macroblock_boundary_marker, frame_ready_out}, 16'h0000);
		report_and_stop();
	end
endmodule
`default_nettype wire
